// ==== hdl/pps_port.sv ====
// Control port register file and PCM highway slot logic
`timescale 1ns/10ps
module pps_port #(
    parameter logic [1:0] PART_ID = 2'h2, // Arbitrary value
    parameter logic [3:0] REV_ID  = 4'h5  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        spi_cs_b_i,
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_sdi_i,
    output logic             spi_sdo_o,
    output logic             spi_sdo_oe_o,
    input  wire logic        pcm_clk_i,
    input  wire logic        frame_sync_i,
    input  wire logic        pcm_drx_i,
    output logic             pcm_dtx_o,
    output logic             pcm_dtx_oe_o,
    input  wire logic [15:0] tx_sample_i,
    output logic             tx_taken_o,
    output logic [15:0]      rx_sample_o,
    output logic             rx_valid_o,
    output logic [1:0]       sample_coding_o
);
    typedef struct packed {
        logic [2:0]           sp_pclk;
        logic [2:0]           sp_frame_sync;
        logic [2:0]           sp_drx;
        logic [2:0]           sp_cs;
        logic [2:0]           sp_sclk;
        logic [2:0]           sp_sdi;
        logic                 chain;
        logic                 rel_mode;
        logic                 xfer_en;
        logic [1:0]           coding;
        logic                 wide;
        logic                 dbl;
        logic                 tri_neg;
        logic [9:0]           tx_off;
        logic [9:0]           rx_off;
        pps_pkg::pps_spi_st_t spi_st;
        logic [2:0]           spi_cnt;
        logic [7:0]           spi_in;
        logic [7:0]           cmd;
        logic [7:0]           spi_out;
        logic                 sdo;
        logic                 sdo_oe;
        logic [15:0]          tx_sh;
        logic                 dtx_oe;
        logic [15:0]          rx_sh;
        logic [15:0]          rx_word;
        logic                 rx_valid;
        logic                 tx_taken;
    } pps_state_t;

    pps_state_t  st;
    pps_state_t  next_st;
    logic        pclk_rise;
    logic        pclk_fall;
    logic        frame;
    logic        cs_rise;
    logic        cs_fall;
    logic        sck_rise;
    logic        sck_fall;
    logic        slot_en;
    logic [7:0]  byte_in;
    logic [7:0]  rdata;
    logic [15:0] rx_next;
    logic [9:0]  offs     [2];
    logic [1:0]  s_start;
    logic [1:0]  s_next;
    logic [1:0]  s_end;
    logic [1:0]  s_sample;
    logic [1:0]  s_final;

    function automatic logic [7:0] read_reg(input pps_state_t s, input logic [6:0] a);
        if (a == pps_pkg::REG_SERIAL_MODE) begin
            read_reg = {s.chain, s.rel_mode, PART_ID, REV_ID};
        end else if (a == pps_pkg::REG_PCM_MODE) begin
            read_reg = {2'h0, s.xfer_en, s.coding, s.wide, s.dbl, s.tri_neg};
        end else if (a == pps_pkg::REG_TX_START_LOW) begin
            read_reg = s.tx_off[7:0];
        end else if (a == pps_pkg::REG_TX_START_HIGH) begin
            read_reg = {6'h00, s.tx_off[9:8]};
        end else if (a == pps_pkg::REG_RX_START_LOW) begin
            read_reg = s.rx_off[7:0];
        end else if (a == pps_pkg::REG_RX_START_HIGH) begin
            read_reg = {6'h00, s.rx_off[9:8]};
        end else begin
            read_reg = 8'h00;
        end
    endfunction

    // Edges come from the second and third stages only
    assign pclk_rise = st.sp_pclk[1] && !st.sp_pclk[2];
    assign pclk_fall = !st.sp_pclk[1] && st.sp_pclk[2];
    assign frame     = pclk_rise && st.sp_frame_sync[1];
    assign cs_rise   = st.sp_cs[1] && !st.sp_cs[2];
    assign cs_fall   = !st.sp_cs[1] && st.sp_cs[2];
    assign sck_rise  = st.sp_sclk[1] && !st.sp_sclk[2];
    assign sck_fall  = !st.sp_sclk[1] && st.sp_sclk[2];
    assign byte_in   = {st.spi_in[6:0], st.sp_sdi[1]};
    assign rdata     = read_reg(st, byte_in[6:0]);
    assign slot_en   = st.xfer_en && (st.coding != pps_pkg::CODE_RSVD);
    assign offs[0]   = st.tx_off;
    assign offs[1]   = st.rx_off;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_slot
            pps_slot u_slot (
                .clk_i        (clk_i),
                .rst_b_i      (rst_b_i),
                .rise_i       (pclk_rise),
                .fall_i       (pclk_fall),
                .frame_i      (frame),
                .enable_i     (slot_en),
                .offset_i     (offs[i]),
                .wide_i       (st.wide),
                .dbl_i        (st.dbl),
                .start_o      (s_start[i]),
                .next_o       (s_next[i]),
                .end_o        (s_end[i]),
                .sample_o     (s_sample[i]),
                .final_fall_o (s_final[i])
            );
        end
    endgenerate

    always_comb begin
        next_st          = st;
        next_st.sp_pclk  = {st.sp_pclk[1:0], pcm_clk_i};
        next_st.sp_frame_sync = {st.sp_frame_sync[1:0], frame_sync_i};
        next_st.sp_drx   = {st.sp_drx[1:0], pcm_drx_i};
        next_st.sp_cs    = {st.sp_cs[1:0], spi_cs_b_i};
        next_st.sp_sclk  = {st.sp_sclk[1:0], spi_sclk_i};
        next_st.sp_sdi   = {st.sp_sdi[1:0], spi_sdi_i};
        next_st.rx_valid = 1'b0;
        next_st.tx_taken = s_start[0];
        rx_next          = {st.rx_sh[14:0], st.sp_drx[1]};

        if (cs_rise) begin
            next_st.spi_st = pps_pkg::SPI_IDLE;
            next_st.sdo_oe = 1'b0;
        end else if (cs_fall) begin
            next_st.spi_st  = pps_pkg::SPI_CMD;
            next_st.spi_cnt = 3'h0;
            next_st.spi_out = 8'h00;
            next_st.sdo_oe  = st.chain;
        end else if (st.spi_st != pps_pkg::SPI_IDLE) begin
            if (sck_rise) begin
                next_st.spi_in  = byte_in;
                next_st.spi_cnt = st.spi_cnt + 3'h1;
                if (st.spi_cnt == pps_pkg::BYTE_LAST) begin
                    case (st.spi_st)
                        pps_pkg::SPI_CMD: begin
                            next_st.cmd    = byte_in;
                            next_st.spi_st = pps_pkg::SPI_DATA;
                            if (byte_in[pps_pkg::READ_BIT]) begin
                                next_st.spi_out = rdata;
                                next_st.sdo_oe  = 1'b1;
                            end else begin
                                // Chain forwards the command a byte late
                                next_st.spi_out = byte_in;
                            end
                        end
                        default: begin
                            next_st.spi_st  = pps_pkg::SPI_CMD;
                            next_st.spi_out = byte_in;
                            if (!st.rel_mode) begin
                                next_st.sdo_oe = 1'b0;
                            end
                            if (!st.cmd[pps_pkg::READ_BIT]) begin
                                if (st.cmd[6:0] == pps_pkg::REG_SERIAL_MODE) begin
                                    next_st.chain    = byte_in[pps_pkg::CHAIN_BIT];
                                    next_st.rel_mode = byte_in[pps_pkg::REL_BIT];
                                end else if (st.cmd[6:0] == pps_pkg::REG_PCM_MODE) begin
                                    next_st.xfer_en = byte_in[pps_pkg::XFER_BIT];
                                    next_st.coding  = byte_in[pps_pkg::CODING_LSB +: 2];
                                    next_st.wide    = byte_in[pps_pkg::WIDTH_BIT];
                                    next_st.dbl     = byte_in[pps_pkg::DBL_BIT];
                                    next_st.tri_neg = byte_in[pps_pkg::TRI_BIT];
                                end else if (st.cmd[6:0] == pps_pkg::REG_TX_START_LOW) begin
                                    next_st.tx_off[7:0] = byte_in;
                                end else if (st.cmd[6:0] == pps_pkg::REG_TX_START_HIGH) begin
                                    next_st.tx_off[9:8] = byte_in[1:0];
                                end else if (st.cmd[6:0] == pps_pkg::REG_RX_START_LOW) begin
                                    next_st.rx_off[7:0] = byte_in;
                                end else if (st.cmd[6:0] == pps_pkg::REG_RX_START_HIGH) begin
                                    next_st.rx_off[9:8] = byte_in[1:0];
                                end
                            end
                        end
                    endcase
                end
            end
            if (sck_fall) begin
                next_st.sdo     = st.spi_out[7];
                next_st.spi_out = {st.spi_out[6:0], 1'b0};
            end
        end

        // Transmit slot
        if (s_start[0]) begin
            next_st.tx_sh  = st.wide ? tx_sample_i : {tx_sample_i[7:0], 8'h00};
            next_st.dtx_oe = 1'b1;
        end else if (s_next[0]) begin
            next_st.tx_sh = {st.tx_sh[14:0], 1'b0};
        end
        if (st.tri_neg ? s_final[0] : s_end[0]) begin
            next_st.dtx_oe = 1'b0;
        end

        // Receive slot
        if (s_sample[1]) begin
            next_st.rx_sh = rx_next;
            if (s_final[1]) begin
                next_st.rx_word  = st.wide ? rx_next : {8'h00, rx_next[7:0]};
                next_st.rx_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            next_st_reset: begin
                st          <= '0;
                st.sp_cs    <= 3'h7;
                st.chain    <= pps_pkg::SERIAL_MODE_RST[pps_pkg::CHAIN_BIT];
                st.rel_mode <= pps_pkg::SERIAL_MODE_RST[pps_pkg::REL_BIT];
                st.xfer_en  <= pps_pkg::PCM_MODE_RST[pps_pkg::XFER_BIT];
                st.coding   <= pps_pkg::PCM_MODE_RST[pps_pkg::CODING_LSB +: 2];
                st.wide     <= pps_pkg::PCM_MODE_RST[pps_pkg::WIDTH_BIT];
                st.dbl      <= pps_pkg::PCM_MODE_RST[pps_pkg::DBL_BIT];
                st.tri_neg  <= pps_pkg::PCM_MODE_RST[pps_pkg::TRI_BIT];
                st.tx_off   <= pps_pkg::START_RST;
                st.rx_off   <= pps_pkg::START_RST;
                st.spi_st   <= pps_pkg::SPI_IDLE;
            end
        end else begin
            st <= next_st;
        end
    end

    assign spi_sdo_o       = st.sdo;
    assign spi_sdo_oe_o    = st.sdo_oe;
    assign pcm_dtx_o       = st.tx_sh[15];
    assign pcm_dtx_oe_o    = st.dtx_oe;
    assign tx_taken_o      = st.tx_taken;
    assign rx_sample_o     = st.rx_word;
    assign rx_valid_o      = st.rx_valid;
    assign sample_coding_o = st.coding;

    // Helper counters watched only by the checks below
    logic       h_seen;
    logic [4:0] h_bits;
    logic [1:0] h_rises;
    logic [9:0] h_since;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            h_seen  <= 1'b0;
            h_bits  <= 5'h00;
            h_rises <= 2'h0;
            h_since <= 10'h000;
        end else begin
            h_seen <= 1'b1;
            if (s_start[0]) begin
                h_bits <= 5'h01;
            end else if (s_next[0]) begin
                h_bits <= h_bits + 5'h01;
            end
            if (s_start[0] || s_next[0]) begin
                h_rises <= 2'h0;
            end else if (pclk_rise && h_rises != 2'h3) begin
                h_rises <= h_rises + 2'h1;
            end
            if (frame) begin
                h_since <= 10'h000;
            end else if (pclk_rise && h_since != pps_pkg::COUNT_MAX) begin
                h_since <= h_since + 10'h001;
            end
        end
    end
    logic [9:0] h_now;
    assign h_now = frame ? 10'h000 : (h_since == pps_pkg::COUNT_MAX ? h_since : h_since + 10'h001);

    a_chain_drive_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cs_fall && st.chain && st.spi_st == pps_pkg::SPI_IDLE |=> spi_sdo_oe_o) else $error("chain mode not driving");
    a_release_at_lsb: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !cs_rise && !cs_fall && sck_rise && st.spi_st == pps_pkg::SPI_DATA && st.spi_cnt == 3'h7 && !st.rel_mode
        |=> !spi_sdo_oe_o) else $error("sdo not released at lsb");
    a_hold_until_cs: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st.rel_mode && spi_sdo_oe_o && !cs_rise && !sck_rise |=> spi_sdo_oe_o) else $error("sdo dropped before cs");
    a_disabled_no_tx: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !st.xfer_en |-> s_start == 2'h0) else $error("transfer while disabled");
    a_reserved_code: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st.coding == pps_pkg::CODE_RSVD |-> s_start == 2'h0 ##1 !tx_taken_o) else $error("reserved coding used");
    a_sample_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_end[0] |-> h_bits == (st.wide ? 5'h10 : 5'h08)) else $error("wrong sample width");
    a_clocks_per_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_next[0] || s_end[0] |-> h_rises == (st.dbl ? 2'h1 : 2'h0)) else $error("wrong clocks per bit");
    a_tri_edge: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (st.tri_neg ? s_final[0] : s_end[0]) |=> !pcm_dtx_oe_o) else $error("dtx not released");
    a_tx_offset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_start[0] |-> h_now == st.tx_off ##1 tx_taken_o && pcm_dtx_oe_o) else $error("tx start misplaced");
    a_rx_offset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_start[1] |-> h_now == st.rx_off) else $error("rx start misplaced");
    a_mode_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !h_seen |-> read_reg(st, pps_pkg::REG_PCM_MODE) == pps_pkg::PCM_MODE_RST) else $error("bad mode reset");
endmodule

// ==== common/pps_pkg.sv ====
// Package: register map, field positions, reset values and state types of the PCM port block
package pps_pkg;
    localparam logic [6:0] REG_SERIAL_MODE   = 7'h00;
    localparam logic [6:0] REG_PCM_MODE      = 7'h01;
    localparam logic [6:0] REG_TX_START_LOW  = 7'h02;
    localparam logic [6:0] REG_TX_START_HIGH = 7'h03;
    localparam logic [6:0] REG_RX_START_LOW  = 7'h04;
    localparam logic [6:0] REG_RX_START_HIGH = 7'h05;

    localparam int CHAIN_BIT  = 7;
    localparam int REL_BIT    = 6;
    localparam int XFER_BIT   = 5;
    localparam int CODING_LSB = 3;
    localparam int WIDTH_BIT  = 2;
    localparam int DBL_BIT    = 1;
    localparam int TRI_BIT    = 0;
    localparam int READ_BIT   = 7;

    localparam logic [7:0] SERIAL_MODE_RST = 8'h00;
    localparam logic [7:0] PCM_MODE_RST    = 8'h08;
    localparam logic [9:0] START_RST       = 10'h000;

    localparam logic [1:0] CODE_ALAW   = 2'h0;
    localparam logic [1:0] CODE_MULAW  = 2'h1;
    localparam logic [1:0] CODE_RSVD   = 2'h2;
    localparam logic [1:0] CODE_LINEAR = 2'h3;

    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam logic [3:0] LAST_BIT8  = 4'h7;
    localparam logic [3:0] LAST_BIT16 = 4'hF;
    localparam logic [9:0] COUNT_MAX  = 10'h3FF;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_CMD,
        SPI_DATA
    } pps_spi_st_t;
endpackage

// ==== hdl/pps_slot.sv ====
// One slot timer: counts bit clocks from frame sync and paces the bits of one sample
`timescale 1ns/10ps
module pps_slot (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       rise_i,
    input  wire logic       fall_i,
    input  wire logic       frame_i,
    input  wire logic       enable_i,
    input  wire logic [9:0] offset_i,
    input  wire logic       wide_i,
    input  wire logic       dbl_i,
    output logic            start_o,
    output logic            next_o,
    output logic            end_o,
    output logic            sample_o,
    output logic            final_fall_o
);
    typedef struct packed {
        logic       armed;
        logic       active;
        logic       phase;
        logic [3:0] bitn;
        logic [9:0] cnt;
    } pps_slot_t;

    pps_slot_t  st;
    pps_slot_t  next_st;
    logic [9:0] cnt_now;
    logic [3:0] last;
    logic       start;
    logic       nxt;
    logic       fin;

    always_comb begin
        next_st = st;
        start   = 1'b0;
        nxt     = 1'b0;
        fin     = 1'b0;
        last    = wide_i ? pps_pkg::LAST_BIT16 : pps_pkg::LAST_BIT8;
        // Frame sync restarts the count from zero
        if (frame_i) begin
            cnt_now = '0;
        end else if (st.cnt == pps_pkg::COUNT_MAX) begin
            cnt_now = st.cnt;
        end else begin
            cnt_now = st.cnt + 10'h001;
        end
        if (rise_i) begin
            next_st.cnt = cnt_now;
            if (frame_i) begin
                next_st.armed = 1'b1;
            end
            if (st.active) begin
                if (dbl_i && !st.phase) begin
                    next_st.phase = 1'b1;
                end else begin
                    next_st.phase = 1'b0;
                    if (st.bitn == last) begin
                        next_st.active = 1'b0;
                        fin            = 1'b1;
                    end else begin
                        next_st.bitn = st.bitn + 4'h1;
                        nxt          = 1'b1;
                    end
                end
            // Slot may not start on the edge that ends the previous one
            end else if ((st.armed || frame_i) && enable_i && cnt_now == offset_i) begin
                next_st.active = 1'b1;
                next_st.bitn   = 4'h0;
                next_st.phase  = 1'b0;
                next_st.armed  = 1'b0;
                start          = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign start_o      = start;
    assign next_o       = nxt;
    assign end_o        = fin;
    assign sample_o     = fall_i && st.active && (st.phase == dbl_i);
    assign final_fall_o = sample_o && (st.bitn == last);
endmodule

// ==== verif/pps_hwy_master.sv ====
// Behavioural PCM highway master: free-running bit clock, frame sync, receive data
`timescale 1ns/10ps
module pps_hwy_master #(
    parameter int FRAME_LEN = 320
) (
    output logic pcm_clk_o,
    output logic frame_sync_o,
    output logic drx_o
);
    int cnt;
    // Continuous 800 ns clock, phase unrelated to the system clock
    initial begin
        pcm_clk_o = 1'b0;
        frame_sync_o = 1'b0;
        drx_o = 1'b0;
        cnt = FRAME_LEN - 1;
        #137;
        forever #400 pcm_clk_o = ~pcm_clk_o;
    end
    // Sync high for exactly the rise that opens each frame
    always @(negedge pcm_clk_o) frame_sync_o <= (cnt == FRAME_LEN - 1);
    // Data moves just after the rise, well clear of the sampling fall
    always @(posedge pcm_clk_o) begin
        cnt = (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
        drx_o <= #50 cnt[1] ^ cnt[4];
    end
endmodule

// ==== verif/testbench.sv ====
// Testbench: register access over the control port and PCM slot timing
`timescale 1ns/10ps
module testbench;
    logic        clk_i, rst_b_i, cs_b, sclk, sdi, sdo, sdo_oe, pclk, fs, drx, dtx, dtx_oe, taken, rxv;
    logic [15:0] tx_s, rx_s, q;
    logic [1:0]  coding;
    logic        om, oz, oc;
    int          fail_count, n_compared, taken_n, valid_n;

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    pps_port #(.PART_ID(2'h1), .REV_ID(4'hA)) uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_cs_b_i(cs_b), .spi_sclk_i(sclk),
        .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .pcm_clk_i(pclk),
        .frame_sync_i(fs), .pcm_drx_i(drx), .pcm_dtx_o(dtx), .pcm_dtx_oe_o(dtx_oe),
        .tx_sample_i(tx_s), .tx_taken_o(taken), .rx_sample_o(rx_s), .rx_valid_o(rxv),
        .sample_coding_o(coding)
    );

    pps_hwy_master #(.FRAME_LEN(320)) hwy (.pcm_clk_o(pclk), .frame_sync_o(fs), .drx_o(drx));

    // Count pulses mid-cycle, clear of the edge that launches them
    always @(negedge clk_i) begin
        taken_n += int'(taken === 1'b1);
        valid_n += int'(rxv === 1'b1);
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    // One command byte plus one data byte; SDO sampled just before each rise
    task automatic spi(input logic [7:0] c, input logic [7:0] d);
        logic [15:0] w;
        w = {c, d};
        cs_b = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = w[i];
            tick(5);
            q[i] = sdo;
            if (i == 15) oc = sdo_oe;
            sclk = 1'b1;
            tick(5);
        end
        tick(2);
        om = sdo_oe;
        sclk = 1'b0;
        tick(5);
        cs_b = 1'b1;
        tick(7);
        oz = sdo_oe;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi({1'b0, a}, d);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
        spi({1'b1, a}, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, q[7:0]});
    endtask

    // Program one slot set-up, skip to a fresh frame, then check every bit clock of it
    task automatic pcm_test(input logic [7:0] m, input logic [9:0] t, input logic [9:0] r, input logic [15:0] s);
        int nb, cpb, ln;
        logic on, act, pact;
        logic [15:0] ex;
        wr(pps_pkg::REG_TX_START_LOW, t[7:0]);
        wr(pps_pkg::REG_TX_START_HIGH, {6'h00, t[9:8]});
        wr(pps_pkg::REG_RX_START_LOW, r[7:0]);
        wr(pps_pkg::REG_RX_START_HIGH, {6'h00, r[9:8]});
        wr(pps_pkg::REG_PCM_MODE, m);
        tx_s = s;
        on = m[5] && (m[4:3] != 2'h2);
        nb = m[2] ? 16 : 8;
        cpb = m[1] ? 2 : 1;
        ln = nb * cpb;
        ex = 16'h0000;
        @(posedge pclk);
        while (fs !== 1'b1) @(posedge pclk);
        taken_n = 0;
        valid_n = 0;
        for (int k = 0; k < 320; k++) begin
            if (k > 0) @(posedge pclk);
            act = on && k >= t && k < t + ln;
            pact = on && k > t && k <= t + ln && !(m[0] && k == t + ln);
            #200;
            if (k > 0) chk("oe_early", {15'h0000, pact}, {15'h0000, dtx_oe});
            #500;
            chk("oe", {15'h0000, act && !(m[0] && k == t + ln - 1)}, {15'h0000, dtx_oe});
            if (act) chk("dtx", {15'h0000, s[nb-1-(k-t)/cpb]}, {15'h0000, dtx});
            if (on && k >= r && k < r + ln && (k - r) % cpb == cpb - 1) ex = {ex[14:0], k[1] ^ k[4]};
        end
        chk("taken", {15'h0000, on}, 16'(taken_n));
        chk("valid", {15'h0000, on}, 16'(valid_n));
        if (on) chk("rx", ex, rx_s);
        chk("coding", {14'h0000, m[4:3]}, {14'h0000, coding});
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is about 28k clocks; cut a hang well beyond that
    initial begin
        #6000000;
        fail_count++;
        end_sim;
    end

    initial begin
        rst_b_i = 1'b0;
        cs_b = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        tx_s = 16'h0000;
        fail_count = 0;
        n_compared = 0;
        repeat (5) @(posedge clk_i);
        #10 rst_b_i = 1'b1;
        tick(2);
        chk("coding_rst", 16'h0001, {14'h0000, coding});
        rd(pps_pkg::REG_PCM_MODE, 8'h08, "pcm_mode_rst");
        rd(pps_pkg::REG_RX_START_LOW, 8'h00, "rx_low_rst");
        rd(pps_pkg::REG_TX_START_HIGH, 8'h00, "tx_high_rst");
        rd(pps_pkg::REG_SERIAL_MODE, 8'h1A, "serial_rst");
        chk("release_lsb", 16'h0000, {15'h0000, om});
        rd(7'h40, 8'h00, "unmapped");
        wr(pps_pkg::REG_SERIAL_MODE, 8'hFF);
        wr(pps_pkg::REG_TX_START_HIGH, 8'hFF);
        chk("chain_echo", 16'h0003, {8'h00, q[7:0]});
        chk("chain_oe", 16'h0001, {15'h0000, oc});
        wr(pps_pkg::REG_SERIAL_MODE, 8'h40);
        rd(pps_pkg::REG_SERIAL_MODE, 8'h5A, "serial_mode");
        chk("plain_oe", 16'h0000, {15'h0000, oc});
        chk("hold_to_cs", 16'h0001, {15'h0000, om});
        chk("release_cs", 16'h0000, {15'h0000, oz});
        rd(pps_pkg::REG_TX_START_HIGH, 8'h03, "tx_high");
        wr(pps_pkg::REG_SERIAL_MODE, 8'h00);
        pcm_test(8'h28, 10'h001, 10'h102, 16'h00C3);
        pcm_test(8'h3F, 10'h103, 10'h005, 16'hA5C3);
        pcm_test(8'h21, 10'h000, 10'h000, 16'h005A);
        pcm_test(8'h34, 10'h001, 10'h001, 16'h1234);
        pcm_test(8'h08, 10'h002, 10'h002, 16'h00FF);
        end_sim;
    end
endmodule
